// ---- pkg/dab_regs.svh ----
// dab block constants: register map, field positions, reset values, widths
`ifndef DAB_REGS_SVH
`define DAB_REGS_SVH
`define DAB_W          48
`define DAB_OBITS      16
`define DAB_OFF_CMD    12'h000
`define DAB_OFF_STAT   12'h004
`define DAB_OFF_FLAGS  12'h008
`define DAB_OFF_OBITS  12'h00c
`define DAB_OFF_A_LO   12'h010
`define DAB_OFF_A_HI   12'h014
`define DAB_OFF_B_LO   12'h018
`define DAB_OFF_B_HI   12'h01c
`define DAB_OFF_R_LO   12'h020
`define DAB_OFF_R_HI   12'h024
`define DAB_CMD_OP_LSB 0
`define DAB_CMD_D_LSB  4
`define DAB_CMD_S_LSB  6
`define DAB_CMD_I_LSB  8
`define DAB_FLG_Z      0
`define DAB_FLG_S      1
`define DAB_FLG_O      2
`define DAB_FLG_C      3
`define DAB_RST_FLAGS  4'h0
`define DAB_RST_OBITS  16'h0000
`define DAB_DIV_CYC    1
`endif

// ---- pkg/dab_pkg.sv ----
// dab package: operation codes, register selectors, flag struct, states
package dab_pkg;
	typedef enum logic [3:0]
	{
		DAB_OP_NOP  = 4'h0,
		DAB_OP_AND  = 4'h1,
		DAB_OP_ADD  = 4'h2,
		DAB_OP_INC  = 4'h3,
		DAB_OP_CLR  = 4'h4,
		DAB_OP_CLEAR_OUTPUT_BIT_OP = 4'h5,
		DAB_OP_BITS = 4'h6,
		DAB_OP_DIV  = 4'h7
	} dab_op_t;
	typedef enum logic [1:0]
	{
		DAB_REG_A = 2'h0,
		DAB_REG_B = 2'h1,
		DAB_REG_R = 2'h2
	} dab_sel_t;
	typedef struct packed
	{
		logic c;
		logic o;
		logic s;
		logic z;
	} dab_flags_t;
	typedef enum logic [1:0]
	{
		DAB_IDLE = 2'b00,
		DAB_EXEC = 2'b01
	} dab_state_t;
endpackage

// ---- rtl/dab_div_step.sv ----
// one restoring division step on the 48-bit registers a, b and r
`timescale 1ns/1ps
module dab_div_step #(
	parameter int W = 48
)(
	// operands
	input  wire logic [W-1:0] a_in,
	input  wire logic [W-1:0] b_in,
	input  wire logic [W-1:0] r_in,
	// results
	output logic      [W-1:0] a_out,
	output logic      [W-1:0] b_out
);
	logic         ge;
	logic [W-1:0] rem;
	// compare, subtract, shift quotient into b and doubled remainder into a
	always_comb
	begin
		ge    = (a_in >= r_in);
		rem   = ge ? (a_in - r_in) : a_in;
		a_out = {rem[W-2:0], 1'b0};
		b_out = {b_in[W-2:0], ge};
	end
endmodule

// ---- rtl/dab_alu.sv ----
// dab_alu: bitwise/arithmetic/division datapath with output-bit bank, on APB
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "dab_regs.svh"
module dab_alu #(
	parameter int W  = `DAB_W,
	parameter int NB = `DAB_OBITS
)(
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// processor side
	output logic      [NB-1:0]         out_bits,
	output dab_pkg::dab_flags_t        flags
);
	import dab_pkg::*;

	logic [W-1:0]  a_q, a_d, b_q, b_d, r_q, r_d;
	dab_flags_t    flg_q, flg_d;
	logic [NB-1:0] ob_q, ob_d;
	logic [31:0]   rd_q, rd_d;
	logic          rdy_q, rdy_d, err_q, err_d;
	dab_state_t    st_q, st_d;
	logic [3:0]    op_q, op_d;
	logic [1:0]    dst_q, dst_d, src_q, src_d;
	logic [3:0]    idx_q, idx_d;
	logic [W-1:0]  div_a, div_b;
	logic          wr, rd;

	assign wr = psel && penable && pwrite && !rdy_q;
	assign rd = psel && penable && !pwrite && !rdy_q;

	// single division step shared by every divide command
	dab_div_step #(
		.W(W)
	) u_div (
		.a_in (a_q),
		.b_in (b_q),
		.r_in (r_q),
		.a_out(div_a),
		.b_out(div_b)
	);

	// read a working register by selector
	function automatic logic [W-1:0] sel_rd(input logic [1:0] s, input logic [W-1:0] a,
		input logic [W-1:0] b, input logic [W-1:0] r);
		if (s == DAB_REG_A)
			sel_rd = a;
		else if (s == DAB_REG_B)
			sel_rd = b;
		else
			sel_rd = r;
	endfunction

	// command capture, execution and register writes
	always_comb
	begin
		logic [W-1:0] x;
		logic [W-1:0] y;
		logic [W:0]   sum;
		logic [W-1:0] res;
		logic         wres;
		x     = '0;
		y     = '0;
		sum   = '0;
		res   = '0;
		wres  = 1'b0;
		a_d   = a_q;  // untouched unless named
		b_d   = b_q;
		r_d   = r_q;
		flg_d = flg_q;
		ob_d  = ob_q;
		st_d  = st_q;
		op_d  = op_q;
		dst_d = dst_q;
		src_d = src_q;
		idx_d = idx_q;
		case (st_q)
			DAB_IDLE:
			begin
				if (wr && paddr == `DAB_OFF_CMD)
				begin
					op_d  = pwdata[`DAB_CMD_OP_LSB +: 4];
					dst_d = pwdata[`DAB_CMD_D_LSB +: 2];
					src_d = pwdata[`DAB_CMD_S_LSB +: 2];
					idx_d = pwdata[`DAB_CMD_I_LSB +: 4];
					st_d  = DAB_EXEC;
				end
			end
			DAB_EXEC:
			begin
				st_d = DAB_IDLE;
				x    = sel_rd(dst_q, a_q, b_q, r_q);
				y    = sel_rd(src_q, a_q, b_q, r_q);
				case (op_q)
					DAB_OP_AND:
					begin
						res     = x & y;
						wres    = (dst_q != src_q) && (dst_q != 2'h3);
						flg_d.c = wres ? 1'b0 : flg_q.c;  // refused form leaves flags alone
						flg_d.o = wres ? 1'b0 : flg_q.o;
					end
					DAB_OP_ADD, DAB_OP_INC:
					begin
						if (op_q == DAB_OP_INC)
							sum = {1'b0, x} + {{W{1'b0}}, 1'b1};
						else
							sum = {1'b0, x} + {1'b0, y};
						res     = sum[W-1:0];
						wres    = (dst_q != 2'h3);
						flg_d.c = wres ? sum[W] : flg_q.c;
						flg_d.o = wres ? ((x[W-1] == y[W-1] || op_q == DAB_OP_INC)
							&& (res[W-1] != x[W-1]) && (op_q != DAB_OP_INC || !x[W-1])) : flg_q.o;
					end
					DAB_OP_CLR:
					begin
						res  = '0;
						wres = (dst_q != 2'h3);
					end
					DAB_OP_CLEAR_OUTPUT_BIT_OP:
						ob_d[idx_q] = 1'b0;
					DAB_OP_BITS:
						ob_d[idx_q] = 1'b1;
					DAB_OP_DIV:
					begin
						a_d     = div_a;
						b_d     = div_b;
						flg_d.s = div_b[W-1];
						flg_d.z = (div_b == '0);
					end
					default:
						st_d = DAB_IDLE;
				endcase
				if (wres)
				begin
					flg_d.s = res[W-1];
					flg_d.z = (res == '0);
					if (dst_q == DAB_REG_A)
						a_d = res;
					else if (dst_q == DAB_REG_B)
						b_d = res;
					else
						r_d = res;
				end
			end
			default:
				st_d = DAB_IDLE;
		endcase
		// direct register loads, refused while a command executes
		if (wr && st_q == DAB_IDLE)
		begin
			if (paddr == `DAB_OFF_A_LO)
				a_d[31:0] = pwdata;
			else if (paddr == `DAB_OFF_A_HI)
				a_d[W-1:32] = pwdata[W-33:0];
			else if (paddr == `DAB_OFF_B_LO)
				b_d[31:0] = pwdata;
			else if (paddr == `DAB_OFF_B_HI)
				b_d[W-1:32] = pwdata[W-33:0];
			else if (paddr == `DAB_OFF_R_LO)
				r_d[31:0] = pwdata;
			else if (paddr == `DAB_OFF_R_HI)
				r_d[W-1:32] = pwdata[W-33:0];
			else if (paddr == `DAB_OFF_FLAGS)
				flg_d = dab_flags_t'(pwdata[3:0]);
			else if (paddr == `DAB_OFF_OBITS)
				ob_d = pwdata[NB-1:0];
		end
	end

	// apb answer: one wait state, read mux, error on unmapped read, on write to DAB_OFF_STAT or above DAB_OFF_R_HI, or on any write while busy
	always_comb
	begin
		rdy_d = (wr || rd);
		err_d = 1'b0;
		rd_d  = rd_q;
		if (rd)
		begin
			if (paddr == `DAB_OFF_CMD)
				rd_d = {20'h0, idx_q, src_q, dst_q, op_q};
			else if (paddr == `DAB_OFF_STAT)
				rd_d = {31'h0, st_q == DAB_EXEC};
			else if (paddr == `DAB_OFF_FLAGS)
				rd_d = {28'h0, flg_q};
			else if (paddr == `DAB_OFF_OBITS)
				rd_d = {{(32-NB){1'b0}}, ob_q};
			else if (paddr == `DAB_OFF_A_LO)
				rd_d = a_q[31:0];
			else if (paddr == `DAB_OFF_A_HI)
				rd_d = {{(64-W){1'b0}}, a_q[W-1:32]};
			else if (paddr == `DAB_OFF_B_LO)
				rd_d = b_q[31:0];
			else if (paddr == `DAB_OFF_B_HI)
				rd_d = {{(64-W){1'b0}}, b_q[W-1:32]};
			else if (paddr == `DAB_OFF_R_LO)
				rd_d = r_q[31:0];
			else if (paddr == `DAB_OFF_R_HI)
				rd_d = {{(64-W){1'b0}}, r_q[W-1:32]};
			else
			begin
				rd_d  = 32'h0;
				err_d = 1'b1;
			end
		end
		else if (wr)
		begin
			rd_d = 32'h0;
			if (paddr == `DAB_OFF_STAT || paddr > `DAB_OFF_R_HI)
				err_d = 1'b1;
			else if (st_q != DAB_IDLE)
				err_d = 1'b1;  // busy: write dropped
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			a_q   <= '0;
			b_q   <= '0;
			r_q   <= '0;
			flg_q <= `DAB_RST_FLAGS;
			ob_q  <= `DAB_RST_OBITS;
			st_q  <= DAB_IDLE;
			op_q  <= 4'h0;
			dst_q <= 2'h0;
			src_q <= 2'h0;
			idx_q <= 4'h0;
			rd_q  <= 32'h0;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			a_q   <= a_d;
			b_q   <= b_d;
			r_q   <= r_d;
			flg_q <= flg_d;
			ob_q  <= ob_d;
			st_q  <= st_d;
			op_q  <= op_d;
			dst_q <= dst_d;
			src_q <= src_d;
			idx_q <= idx_d;
			rd_q  <= rd_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end

	assign prdata   = rd_q;
	assign pready   = rdy_q;
	assign pslverr  = err_q;
	assign out_bits = ob_q;
	assign flags    = flg_q;
endmodule

// ---- verif/dab_alu_chk.sv ----
// dab_alu checker: command effects seen at the ports
`timescale 1ns/1ps
module dab_alu_chk #(
	parameter int NB = 16
)(
	// clock, reset and apb
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// processor side
	input wire logic [NB-1:0]	out_bits,
	input wire dab_pkg::dab_flags_t	flags
);
	import dab_pkg::*;
	// command write taken at the first access edge, with its fields
	wire cmd = psel && penable && pwrite && !pready && paddr == 12'h000;
	wire [3:0] op = pwdata[3:0];
	wire [3:0] ix = pwdata[11:8];
	wire dok = pwdata[5:4] != 2'h3;
	wire aok = dok && pwdata[7:6] != 2'h3 && pwdata[5:4] != pwdata[7:6];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// results are visible two edges after the command is taken
	AST_ANSWER: assert property (psel && penable && !pready |=> pready)
		else $error("no answer");
	AST_BITS: assert property (cmd && op == 4'h6 |->
		##2 out_bits[$past(ix, 2)] && $stable(flags)) else $error("bit set");
	AST_CLEAR_OUTPUT_BIT_OP: assert property (cmd && op == 4'h5 |->
		##2 !out_bits[$past(ix, 2)] && $stable(flags)) else $error("bit clear");
	AST_OBITS_KEEP: assert property (cmd && op inside {[4'h0:4'h4], 4'h7} |->
		##2 $stable(out_bits)) else $error("output bits moved");
	AST_NOP: assert property (cmd && op == 4'h0 |-> ##2 $stable(flags))
		else $error("nop moved flags");
	AST_CLR: assert property (cmd && op == 4'h4 && dok |->
		##2 !flags.s && flags.z && $stable(flags.c) && $stable(flags.o)) else $error("clear");
	AST_DIV: assert property (cmd && op == 4'h7 |->
		##2 $stable(flags.c) && $stable(flags.o)) else $error("divide flags");
	AST_AND: assert property (cmd && op == 4'h1 && aok |->
		##2 !flags.c && !flags.o) else $error("and flags");
	AST_AND_SAME: assert property (cmd && op == 4'h1 && !aok |->
		##2 $stable(flags)) else $error("refused and moved flags");
	// main scenarios
	cover property (cmd && op == 4'h7);
	cover property (cmd && op == 4'h6);
	cover property (cmd && op == 4'h2);
endmodule

// ---- verif/tb.sv ----
// dab_alu testbench: apb driver, reference model and scenarios
`timescale 1ns/1ps
`include "dab_regs.svh"
module tb;
	import dab_pkg::*;
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rdat, seed;
	logic [15:0]	out_bits, mo;
	dab_flags_t	flags;
	logic [47:0]	m [3];
	logic [3:0]	mf;
	int	error_cnt, n_compared;
	dab_alu i_dab_alu
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .out_bits, .flags
	);
	// 200 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// lfsr stimulus source
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
			error_cnt++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wreg(input int i, input logic [47:0] v);
		m[i] = v;
		apb(1'b1, `DAB_OFF_A_LO + 12'(8 * i), v[31:0]);
		apb(1'b1, `DAB_OFF_A_HI + 12'(8 * i), {16'h0000, v[47:32]});
	endtask
	// read back the a, b and r registers, flags and output bits against the model
	task automatic chk_all();
		logic [31:0] lo;
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, `DAB_OFF_A_LO + 12'(8 * i), 32'h0);
			lo = rdat;
			apb(1'b0, `DAB_OFF_A_HI + 12'(8 * i), 32'h0);
			cmp("reg", {16'h0000, m[i]}, {rdat, lo});
		end
		apb(1'b0, `DAB_OFF_FLAGS, 32'h0);
		cmp("flags", {60'h0, mf}, {60'h0, flags});
		cmp("flag_reg", {60'h0, mf}, {32'h0, rdat});
		apb(1'b0, `DAB_OFF_OBITS, 32'h0);
		cmp("obits", {48'h0, mo}, {32'h0, rdat});
	endtask
	// issue a command and step the model
	task automatic run(input logic [3:0] op, input int d, input int s, input int ix);
		logic [48:0] t;
		logic [47:0] e;
		logic ge;
		apb(1'b1, `DAB_OFF_CMD, {20'h0, 4'(ix), 2'(s), 2'(d), op});
		if (op == 4'h1 && d != s && d < 3)
		begin
			m[d] = m[d] & m[s];
			mf = {2'b00, m[d][47], m[d] == 48'h0};
		end
		if ((op == 4'h2 || op == 4'h3) && d < 3)
		begin
			e = (op == 4'h2) ? m[s] : 48'h1;
			t = m[d] + e;
			mf = {t[48], m[d][47] == e[47] && t[47] != m[d][47], t[47], t[47:0] == 48'h0};
			m[d] = t[47:0];
		end
		if (op == 4'h4 && d < 3)
		begin
			m[d] = 48'h0;
			mf[1:0] = 2'b01;
		end
		if (op == 4'h5 || op == 4'h6)
			mo[ix] = op[1];
		if (op == 4'h7)
		begin
			ge = m[0] >= m[2];
			m[0] = (ge ? m[0] - m[2] : m[0]) << 1;
			m[1] = {m[1][46:0], ge};
			mf[1:0] = {m[1][47], m[1] == 48'h0};
		end
		chk_all();
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{seed, error_cnt, n_compared, mf, mo} = {32'h12, 64'h0, 20'h0};
		m = '{default: 48'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk_all();
		for (int k = 0; k < 30; k++)
		begin
			for (int i = 0; i < 3; i++)
				wreg(i, (rnd() % 4 == 0) ? '1 : 48'({rnd(), rnd()}));
			mf = 4'(rnd());
			apb(1'b1, `DAB_OFF_FLAGS, {28'h0, mf});
			run(4'(rnd() % 5), int'(rnd() % 4), int'(rnd() % 3), 0);
		end
		for (int i = 0; i < 32; i++)
			run(i < 16 ? 4'h6 : 4'h5, 0, 0, (i * 7) % 16);
		for (int k = 1; k < 5; k++)
		begin
			wreg(2, {2'b00, 46'({rnd(), rnd()})} + 48'h1);
			wreg(0, 48'({rnd(), rnd()}) % (2 * m[2] - 48'h1) + 48'h1);
			wreg(1, 48'h0);
			repeat (k) run(4'h7, 0, 0, 0);
		end
		apb(1'b0, 12'h030, 32'h0);
		cmp("unmapped", 64'h1_0000_0000, {31'h0, rerr, rdat});
		end_of_test();
	end
endmodule
bind dab_alu dab_alu_chk #(.NB(NB)) i_dab_alu_chk
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .out_bits, .flags
);
